// ==== include/ide_port_pkg.sv ====
// Constants and carrier types for the drive-side host port signalling.
// Assumes a single 10 MHz reference clock and host pins synchronous to it.
package ide_port_pkg;

	localparam int          CLK_PERIOD_NS    = 100;
	// Window after reset release in which a secondary drive announces itself.
	localparam int          PRESENCE_NS      = 1000;
	localparam int          PRESENCE_CYCLES  = (PRESENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Port numbers inside each chip-select space.
	localparam logic [2:0]  PORT_DATA        = 3'h0;
	localparam logic [2:0]  PORT_DRIVE_HEAD  = 3'h6;
	localparam logic [2:0]  PORT_STATUS      = 3'h7;
	localparam logic [2:0]  PORT_AUX_ALT     = 3'h6;

	// Drive-select bit inside the drive/head select port.
	localparam int          DRIVE_SEL_BIT    = 4;
	localparam logic [7:0]  DRIVE_HEAD_RESET = 8'h00;

	typedef struct packed {
		logic        aux;
		logic [2:0]  port;
		logic [15:0] data;
	} host_write_t;

	typedef struct packed {
		logic        aux;
		logic [2:0]  port;
	} host_read_t;

	typedef enum {PRES_STRAP, PRES_ANNOUNCE, PRES_RUN} presence_state_t;

endpackage

// ==== rtl/ide_host_port.sv ====
// Drive-side logic behind the host parallel port: decode, strobes, lanes,
// interrupt, wide-transfer indication and the daisy-chain lines.
// Assumes host pins are synchronous to ref_clk and the drive core answers
// a read request in the same cycle it sees it.
//
// Contract
// - Host reset returns all interface logic to its initial state.
// - Low eight lanes are the bidirectional bus for control and status.
// - High eight lanes carry data only during 16-bit data transfers.
// - Drive raises interrupt request when it needs host service.
// - Drive asserts wide-transfer indicator for 16-bit data transfers.
// - Three address lines pick one of eight ports in active space.
// - Secondary drives diag-passed line after diagnostics; primary only listens.
// - Activity/presence line is open-collector and time multiplexed.
// - At reset secondary announces presence; primary samples the line.
// - Outside reset and diagnostics, line asserted while a command executes.
// - While busy only status answers in primary space; alternate status always.
// - Unselected drive ignores commands and drives no status.
`timescale 1ns/1ps
module ide_host_port #(
	parameter int PRESENCE_CYCLES = ide_port_pkg::PRESENCE_CYCLES
) (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	// Host address, selects and strobes
	input  wire logic [2:0]                host_port_address,
	input  wire logic                      primary_port_select_n,
	input  wire logic                      auxiliary_port_select_n,
	input  wire logic                      io_read_strobe_n,
	input  wire logic                      io_write_strobe_n,
	// Host data lanes
	input  wire logic [7:0]                host_data_low_lanes_in,
	output logic      [7:0]                host_data_low_lanes_out,
	output logic                           host_data_low_lanes_oe,
	input  wire logic [7:0]                host_data_high_lanes_in,
	output logic      [7:0]                host_data_high_lanes_out,
	output logic                           host_data_high_lanes_oe,
	// Host indications
	output logic                           host_interrupt_request,
	output logic                           wide_transfer_indicator_n,
	// Daisy-chain open-collector lines
	input  wire logic                      diag_passed_line_n_in,
	output logic                           diag_passed_line_n_out,
	output logic                           diag_passed_line_n_oe,
	input  wire logic                      active_or_secondary_present_n_in,
	output logic                           active_or_secondary_present_n_out,
	output logic                           active_or_secondary_present_n_oe,
	// Configuration jumper
	input  wire logic                      secondary_strap,
	// Drive core side
	input  wire logic                      core_busy,
	input  wire logic [7:0]                core_status,
	input  wire logic [15:0]               core_read_data,
	input  wire logic                      core_irq_set,
	input  wire logic                      core_cmd_active,
	input  wire logic                      core_diag_running,
	input  wire logic                      core_diag_ok,
	output ide_port_pkg::host_write_t      core_write,
	output logic                           core_write_valid,
	output ide_port_pkg::host_read_t       core_read,
	output logic                           core_read_valid,
	output logic                           secondary_present,
	output logic                           secondary_diag_passed
);

	localparam int CNT_W = $clog2(PRESENCE_CYCLES + 1);

	generate
		if (PRESENCE_CYCLES < 2) begin : g_bad_presence
			$error("PRESENCE_CYCLES must be at least 2.");
		end
	endgenerate

	ide_port_pkg::presence_state_t state_reg;
	logic [CNT_W-1:0] pres_cnt_reg;
	logic             cfg_secondary_reg;
	logic [7:0]       drive_head_reg;
	logic             rd_active_reg;
	logic             rd_wide_reg;
	logic             rd_status_reg;
	logic [1:0]       fall;
	logic [1:0]       rise;
	logic             rd_fall;
	logic             wr_rise;
	logic             prim;
	logic             auxsel;
	logic             selected;
	logic             read_ok;
	logic             write_ok;

	strobe_edges #(
		.WIDTH (2)
	) u_edges (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.level_n ({io_write_strobe_n, io_read_strobe_n}),
		.fall    (fall),
		.rise    (rise)
	);

	assign rd_fall = fall[0];
	assign wr_rise = rise[1];

	// Exactly one select low makes an access; both low is refused.
	assign prim     = ~primary_port_select_n & auxiliary_port_select_n;
	assign auxsel   = ~auxiliary_port_select_n & primary_port_select_n;
	assign selected = (drive_head_reg[ide_port_pkg::DRIVE_SEL_BIT] == cfg_secondary_reg);

	// The alternate status stays readable for polling while busy.
	assign read_ok  = selected & ((prim & (~core_busy
		| host_port_address == ide_port_pkg::PORT_STATUS)) | auxsel);
	assign write_ok = (prim & selected & ~core_busy) | auxsel;

	// Strap is caught after reset release, never under the reset itself.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg         <= ide_port_pkg::PRES_STRAP;
			pres_cnt_reg      <= '0;
			cfg_secondary_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ide_port_pkg::PRES_STRAP: begin
					cfg_secondary_reg <= secondary_strap;
					pres_cnt_reg      <= '0;
					state_reg         <= ide_port_pkg::PRES_ANNOUNCE;
				end
				ide_port_pkg::PRES_ANNOUNCE: begin
					pres_cnt_reg <= pres_cnt_reg + CNT_W'(1);
					if (pres_cnt_reg == CNT_W'(PRESENCE_CYCLES - 1)) begin
						state_reg <= ide_port_pkg::PRES_RUN;
					end
				end
				ide_port_pkg::PRES_RUN: begin
					state_reg <= ide_port_pkg::PRES_RUN;
				end
			endcase
		end
	end

	// Primary samples at the end of the window, after the secondary has driven it.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			secondary_present <= 1'b0;
		end else if (state_reg == ide_port_pkg::PRES_ANNOUNCE && !cfg_secondary_reg
			&& pres_cnt_reg == CNT_W'(PRESENCE_CYCLES - 1)) begin
			secondary_present <= ~active_or_secondary_present_n_in;
		end
	end

	// Activity/presence line: presence during the window, activity afterwards.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_or_secondary_present_n_oe <= 1'b0;
		end else if (state_reg == ide_port_pkg::PRES_ANNOUNCE) begin
			active_or_secondary_present_n_oe <= cfg_secondary_reg;
		end else if (state_reg == ide_port_pkg::PRES_RUN) begin
			active_or_secondary_present_n_oe <= core_cmd_active & ~core_diag_running;
		end else begin
			active_or_secondary_present_n_oe <= 1'b0;
		end
	end

	// Diagnostic line: driven only by a secondary, heard only by a primary.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			diag_passed_line_n_oe <= 1'b0;
			secondary_diag_passed <= 1'b0;
		end else begin
			diag_passed_line_n_oe <= cfg_secondary_reg & core_diag_ok
				& (state_reg == ide_port_pkg::PRES_RUN);
			secondary_diag_passed <= ~cfg_secondary_reg & ~diag_passed_line_n_in;
		end
	end

	// Open-collector lines only ever pull low.
	assign active_or_secondary_present_n_out = 1'b0;
	assign diag_passed_line_n_out            = 1'b0;

	// Both drives track the select port so either can become addressed.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_head_reg <= ide_port_pkg::DRIVE_HEAD_RESET;
		end else if (wr_rise && prim && !core_busy
			&& host_port_address == ide_port_pkg::PORT_DRIVE_HEAD) begin
			drive_head_reg <= host_data_low_lanes_in;
		end
	end

	// Writes are taken on the trailing edge, when host data is settled.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_write_valid <= 1'b0;
			core_write       <= '0;
		end else begin
			core_write_valid <= wr_rise & write_ok;
			if (wr_rise && write_ok) begin
				core_write.aux  <= auxsel;
				core_write.port <= host_port_address;
				core_write.data <= {host_data_high_lanes_in, host_data_low_lanes_in};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_read_valid <= 1'b0;
			core_read       <= '0;
			rd_active_reg   <= 1'b0;
			rd_wide_reg     <= 1'b0;
			rd_status_reg   <= 1'b0;
		end else begin
			core_read_valid <= rd_fall & read_ok;
			if (rd_fall && read_ok) begin
				core_read.aux  <= auxsel;
				core_read.port <= host_port_address;
				rd_active_reg  <= 1'b1;
				rd_wide_reg    <= prim & (host_port_address == ide_port_pkg::PORT_DATA);
				rd_status_reg  <= ~prim | (host_port_address == ide_port_pkg::PORT_STATUS);
			end else if (rise[0]) begin
				rd_active_reg <= 1'b0;
				rd_wide_reg   <= 1'b0;
			end
		end
	end

	// Lane data appears one cycle after the request, while the strobe is low.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_data_low_lanes_out  <= '0;
			host_data_high_lanes_out <= '0;
			host_data_low_lanes_oe   <= 1'b0;
			host_data_high_lanes_oe  <= 1'b0;
		end else begin
			host_data_low_lanes_oe  <= rd_active_reg & ~rise[0];
			host_data_high_lanes_oe <= rd_wide_reg & ~rise[0];
			if (core_read_valid) begin
				host_data_low_lanes_out  <= rd_status_reg ? core_status : core_read_data[7:0];
				host_data_high_lanes_out <= rd_status_reg ? 8'h00 : core_read_data[15:8];
			end
		end
	end

	// A new core event wins over a clear in the same cycle.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_interrupt_request <= 1'b0;
		end else if (core_irq_set) begin
			host_interrupt_request <= 1'b1;
		end else if (prim && selected && host_port_address == ide_port_pkg::PORT_STATUS
			&& ((rd_fall && read_ok) || (wr_rise && write_ok))) begin
			host_interrupt_request <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wide_transfer_indicator_n <= 1'b1;
		end else begin
			wide_transfer_indicator_n <= ~(prim & selected & ~core_busy
				& host_port_address == ide_port_pkg::PORT_DATA);
		end
	end

	sequence s_read_start;
		rd_fall && read_ok;
	endsequence

	sequence s_write_taken;
		wr_rise && write_ok;
	endsequence

	chk_irq_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		core_irq_set |=> host_interrupt_request)
		else $error("Interrupt request not raised after core event.");

	chk_irq_status_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_read_start and (prim && host_port_address == ide_port_pkg::PORT_STATUS
		&& !core_irq_set))
		|=> !host_interrupt_request)
		else $error("Status read did not clear interrupt request.");

	chk_wide_data_port: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(prim && selected && !core_busy && host_port_address == ide_port_pkg::PORT_DATA)
		|=> !wide_transfer_indicator_n)
		else $error("Wide-transfer indicator missing on data port.");

	chk_high_lane_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s_read_start and host_port_address != ide_port_pkg::PORT_DATA)
		|=> ##1 !host_data_high_lanes_oe)
		else $error("High lanes driven on a byte access.");

	chk_read_drives_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_read_start ##1 (core_read_valid && !io_read_strobe_n) |=> host_data_low_lanes_oe)
		else $error("Low lanes not driven during read.");

	chk_busy_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_fall && prim && core_busy && host_port_address != ide_port_pkg::PORT_STATUS)
		|=> !core_read_valid)
		else $error("Non-status port answered while busy.");

	chk_alt_status_always: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(rd_fall && auxsel && selected && host_port_address == ide_port_pkg::PORT_AUX_ALT)
		|=> core_read_valid)
		else $error("Alternate status did not answer.");

	chk_unselected_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_rise && prim && !selected) |=> !core_write_valid)
		else $error("Unselected drive accepted a write.");

	chk_write_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_write_taken |=> core_write_valid
		&& core_write.data == $past({host_data_high_lanes_in, host_data_low_lanes_in}))
		else $error("Write data not passed to core.");

	chk_two_selects: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_rise && !primary_port_select_n && !auxiliary_port_select_n) |=> !core_write_valid)
		else $error("Access taken with both selects low.");

	chk_announce_line: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == ide_port_pkg::PRES_ANNOUNCE && cfg_secondary_reg)
		|=> active_or_secondary_present_n_oe)
		else $error("Secondary did not announce presence.");

	chk_activity_line: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == ide_port_pkg::PRES_RUN && core_cmd_active && !core_diag_running)
		|=> active_or_secondary_present_n_oe)
		else $error("Activity not shown during command.");

	chk_primary_diag_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!cfg_secondary_reg && state_reg != ide_port_pkg::PRES_STRAP) |=> !diag_passed_line_n_oe)
		else $error("Primary drove the diagnostic line.");

endmodule

// ==== rtl/strobe_edges.sv ====
// Edge finder for a group of active-low host strobes.
// Assumes the strobes are already synchronous to ref_clk.
`timescale 1ns/1ps
module strobe_edges #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Strobe levels and their edges
	input  wire logic [WIDTH-1:0] level_n,
	output logic      [WIDTH-1:0] fall,
	output logic      [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] prev_reg;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("strobe_edges needs at least one strobe.");
		end
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			// Idle level is high, so no edge is seen straight after reset.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					prev_reg[i] <= 1'b1;
				end else begin
					prev_reg[i] <= level_n[i];
				end
			end
			assign fall[i] = prev_reg[i] & ~level_n[i];
			assign rise[i] = ~prev_reg[i] & level_n[i];
		end
	endgenerate

endmodule

// ==== testbench/ide_host_port_tb.sv ====
// Self-checking bench for the drive-side host port logic.
// Assumes the peer model resolves the open-collector lines.
`timescale 1ns/1ps
module ide_host_port_tb;
	localparam int PRES = 2;
	logic ref_clk = 1'h0;
	logic rst_n, secondary_strap, core_busy, core_irq_set, core_cmd_active;
	logic core_diag_running, core_diag_ok, peer_present, peer_diag, peer_cmd;
	logic [2:0] host_port_address;
	logic [1:0] sel_n;
	logic io_read_strobe_n, io_write_strobe_n;
	logic [7:0] host_lo, host_hi, core_status;
	logic [15:0] core_read_data;
	logic [7:0] lo_out, hi_out;
	logic lo_oe, hi_oe, irq, wide_n, diag_out, diag_oe, act_out, act_oe;
	logic diag_n, act_n, wr_valid, rd_valid, sec_present, sec_diag;
	ide_port_pkg::host_write_t core_write, r_wr;
	ide_port_pkg::host_read_t core_read, r_rd;
	int n_mismatch = 0;
	int tests_run = 0;
	int r_valid;
	logic [15:0] r_data;
	logic [1:0] r_oe, r_oe_end;
	logic r_wide, r_act_seen;

	always #50 ref_clk = ~ref_clk;

	ide_host_port #(.PRESENCE_CYCLES(PRES)) i_ide_host_port (
		.ref_clk(ref_clk), .rst_n(rst_n), .host_port_address(host_port_address),
		.primary_port_select_n(sel_n[0]), .auxiliary_port_select_n(sel_n[1]),
		.io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
		.host_data_low_lanes_in(lo_oe ? lo_out : host_lo),
		.host_data_low_lanes_out(lo_out), .host_data_low_lanes_oe(lo_oe),
		.host_data_high_lanes_in(hi_oe ? hi_out : host_hi),
		.host_data_high_lanes_out(hi_out), .host_data_high_lanes_oe(hi_oe),
		.host_interrupt_request(irq), .wide_transfer_indicator_n(wide_n),
		.diag_passed_line_n_in(diag_n), .diag_passed_line_n_out(diag_out),
		.diag_passed_line_n_oe(diag_oe), .active_or_secondary_present_n_in(act_n),
		.active_or_secondary_present_n_out(act_out),
		.active_or_secondary_present_n_oe(act_oe), .secondary_strap(secondary_strap),
		.core_busy(core_busy), .core_status(core_status), .core_read_data(core_read_data),
		.core_irq_set(core_irq_set), .core_cmd_active(core_cmd_active),
		.core_diag_running(core_diag_running), .core_diag_ok(core_diag_ok),
		.core_write(core_write), .core_write_valid(wr_valid), .core_read(core_read),
		.core_read_valid(rd_valid), .secondary_present(sec_present),
		.secondary_diag_passed(sec_diag));

	peer_drive_model #(.ANNOUNCE_CYCLES(PRES + 4)) i_peer_drive_model (
		.ref_clk(ref_clk), .rst_n(rst_n), .present(peer_present), .diag_ok(peer_diag),
		.cmd_active(peer_cmd), .diag_oe(diag_oe), .diag_out(diag_out), .act_oe(act_oe),
		.act_out(act_out), .diag_line_n(diag_n), .act_line_n(act_n));

	task automatic expect_eq(input logic [19:0] got, input logic [19:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t ns: %s", $time, what);
			n_mismatch++;
		end
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic do_reset(input logic strap, input logic peer);
		@(negedge ref_clk);
		rst_n = 1'h0;
		secondary_strap = strap;
		peer_present = peer;
		repeat (16) @(negedge ref_clk);
		expect_eq({lo_oe, hi_oe, diag_oe, act_oe, irq, wr_valid, rd_valid, sec_present, wide_n},
			20'h0_0001, "outputs not idle in reset");
		rst_n = 1'h1;
		r_act_seen = 1'h0;
		repeat (PRES + 4) begin
			@(negedge ref_clk);
			if (act_oe === 1'h1) r_act_seen = 1'h1;
		end
	endtask

	task automatic host_read(input logic [1:0] sel, input logic [2:0] port);
		r_valid = 0;
		r_wide = 1'h0;
		@(negedge ref_clk);
		sel_n = sel;
		host_port_address = port;
		@(negedge ref_clk);
		io_read_strobe_n = 1'h0;
		repeat (4) begin
			@(negedge ref_clk);
			if (rd_valid === 1'h1) begin
				r_valid++;
				r_rd = core_read;
			end
			if (wide_n === 1'h0) r_wide = 1'h1;
		end
		r_data = {hi_out, lo_out};
		r_oe = {hi_oe, lo_oe};
		io_read_strobe_n = 1'h1;
		repeat (2) @(negedge ref_clk);
		r_oe_end = {hi_oe, lo_oe};
		sel_n = 2'h3;
	endtask

	task automatic host_write(input logic [1:0] sel, input logic [2:0] port, input logic [15:0] d);
		r_valid = 0;
		@(negedge ref_clk);
		sel_n = sel;
		host_port_address = port;
		{host_hi, host_lo} = d;
		io_write_strobe_n = 1'h0;
		repeat (2) @(negedge ref_clk);
		io_write_strobe_n = 1'h1;
		repeat (3) begin
			@(negedge ref_clk);
			if (wr_valid === 1'h1) begin
				r_valid++;
				r_wr = core_write;
			end
		end
		sel_n = 2'h3;
		{host_hi, host_lo} = ~d;
	endtask

	task automatic t_writes();
		for (int p = 0; p < 8; p++) begin
			host_write(2'h2, 3'(p), {8'h3c, 5'h00, 3'(p)});
			expect_eq(20'(r_valid), 20'h0_0001, "write not taken");
			expect_eq(r_wr, {1'h0, 3'(p), 8'h3c, 5'h00, 3'(p)}, "write content");
		end
		host_write(2'h1, 3'h6, 16'h0004);
		expect_eq(r_wr, {1'h1, 3'h6, 16'h0004}, "aux write");
	endtask

	task automatic t_reads();
		core_read_data = 16'h9e71;
		core_status = 8'h5a;
		host_read(2'h2, 3'h0);
		expect_eq({r_data, r_oe, r_oe_end}, {16'h9e71, 2'h3, 2'h0}, "data word read");
		expect_eq({12'(r_valid), r_rd, r_wide}, {12'h001, 1'h0, 3'h0, 1'h1}, "wide read");
		host_read(2'h2, 3'h7);
		expect_eq({r_data, r_oe, r_wide}, {16'h005a, 2'h1, 1'h0}, "status read");
		host_read(2'h1, 3'h6);
		expect_eq({r_data, r_rd}, {16'h005a, 1'h1, 3'h6}, "alt status read");
	endtask

	task automatic t_busy_and_selects();
		core_busy = 1'h1;
		host_read(2'h2, 3'h1);
		expect_eq({12'(r_valid), r_oe}, 14'h0, "busy read answered");
		host_write(2'h2, 3'h3, 16'h0011);
		expect_eq(20'(r_valid), 20'h0, "busy write taken");
		host_read(2'h2, 3'h7);
		expect_eq(20'(r_valid), 20'h0_0001, "busy status refused");
		host_read(2'h1, 3'h6);
		expect_eq(20'(r_valid), 20'h0_0001, "busy alt status refused");
		core_busy = 1'h0;
		host_read(2'h0, 3'h7);
		expect_eq({12'(r_valid), r_oe}, 14'h0, "two selects answered");
		host_write(2'h0, 3'h3, 16'h0033);
		expect_eq(20'(r_valid), 20'h0, "two selects write taken");
		host_read(2'h3, 3'h7);
		expect_eq({12'(r_valid), r_oe}, 14'h0, "no select answered");
	endtask

	task automatic t_irq();
		@(negedge ref_clk);
		core_irq_set = 1'h1;
		@(negedge ref_clk);
		core_irq_set = 1'h0;
		expect_eq(20'(irq), 20'h0_0001, "irq not raised");
		host_read(2'h2, 3'h1);
		expect_eq(20'(irq), 20'h0_0001, "irq lost on other port");
		host_read(2'h2, 3'h7);
		expect_eq(20'(irq), 20'h0, "irq not cleared");
	endtask

	task automatic t_drive_select();
		host_write(2'h2, 3'h6, 16'h0010);
		host_read(2'h2, 3'h7);
		expect_eq({12'(r_valid), r_oe}, 14'h0, "deselected drive answered");
		host_write(2'h2, 3'h3, 16'h0022);
		expect_eq(20'(r_valid), 20'h0, "deselected write taken");
		do_reset(1'h0, 1'h0);
		host_read(2'h2, 3'h7);
		expect_eq(20'(r_valid), 20'h0_0001, "select not reset");
	endtask

	task automatic t_daisy_chain();
		do_reset(1'h0, 1'h1);
		expect_eq({sec_present, r_act_seen}, 20'h0_0002, "peer presence");
		peer_diag = 1'h1;
		peer_cmd = 1'h1;
		repeat (3) @(negedge ref_clk);
		expect_eq({sec_diag, diag_oe, sec_present, act_oe}, 20'h0_000a, "primary diag line");
		do_reset(1'h1, 1'h0);
		expect_eq({r_act_seen, act_oe, sec_present}, 20'h0_0004, "secondary announce");
		core_diag_ok = 1'h1;
		core_cmd_active = 1'h1;
		repeat (3) @(negedge ref_clk);
		expect_eq({diag_oe, act_oe, act_out, diag_out}, 20'h0_000c, "secondary lines");
		core_diag_running = 1'h1;
		repeat (3) @(negedge ref_clk);
		expect_eq(20'(act_oe), 20'h0, "active during diagnostics");
		{core_diag_ok, core_cmd_active, core_diag_running, peer_diag, peer_cmd} = 5'h00;
		do_reset(1'h0, 1'h0);
		expect_eq({sec_present, r_act_seen}, 20'h0, "primary drove presence");
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end

	initial begin
		{rst_n, secondary_strap, core_busy, core_irq_set, core_cmd_active} = 5'h0;
		{core_diag_running, core_diag_ok, peer_present, peer_diag, peer_cmd} = 5'h0;
		{sel_n, io_read_strobe_n, io_write_strobe_n} = 4'hf;
		host_port_address = 3'h0;
		{host_hi, host_lo} = 16'h0000;
		core_status = 8'h00;
		core_read_data = 16'h0000;
		do_reset(1'h0, 1'h0);
		t_writes();
		t_reads();
		t_busy_and_selects();
		t_irq();
		t_drive_select();
		t_daisy_chain();
		summarize();
	end
endmodule

// ==== testbench/peer_drive_model.sv ====
// Model of the second drive sharing the daisy-chain lines, with the pull-ups.
// Assumes the bench picks whether the peer is fitted and what it reports.
`timescale 1ns/1ps
module peer_drive_model #(
	parameter int ANNOUNCE_CYCLES = 6
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// Peer behaviour
	input  wire logic present,
	input  wire logic diag_ok,
	input  wire logic cmd_active,
	// Device side of the shared lines
	input  wire logic diag_oe,
	input  wire logic diag_out,
	input  wire logic act_oe,
	input  wire logic act_out,
	// Resolved line levels
	output logic      diag_line_n,
	output logic      act_line_n
);
	logic [3:0] since_reset_reg;
	logic       act_pull;
	logic       diag_pull;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			since_reset_reg <= 4'h0;
		end else if (since_reset_reg != 4'hf) begin
			since_reset_reg <= since_reset_reg + 4'h1;
		end
	end

	// Presence is held a little past the window so the sampling edge never races it.
	assign act_pull = present & ((int'(since_reset_reg) < ANNOUNCE_CYCLES) | cmd_active);
	assign diag_pull = present & diag_ok;
	// A released line floats to the pull-up; any party pulling low wins.
	assign act_line_n = !(act_pull | (act_oe & !act_out));
	assign diag_line_n = !(diag_pull | (diag_oe & !diag_out));
endmodule
